//--- design/cpu_register_set_and_flags.sv
`timescale 1ns/1ns
module cpu_register_set_and_flags
  import cpu_regs_pkg::*;
(
  input  wire logic                            clk_sys_i,
  input  wire logic                            rst_b_i,
  // Register file write port
  input  wire cpu_regs_pkg::wr_size_t          wr_size_i,
  input  wire logic [cpu_regs_pkg::SEL_W-1:0]  wr_sel_i,
  input  wire logic [15:0]                     wr_data_i,
  // Data read port A (byte select uses hi flag)
  input  wire logic [cpu_regs_pkg::SEL_W-1:0]  rd_sel_i,
  input  wire logic                            rd_byte_i,
  input  wire logic                            rd_high_i,
  output logic      [15:0]                     rd_data_o,
  // Address read port, always a full word
  input  wire logic [cpu_regs_pkg::SEL_W-1:0]  addr_sel_i,
  input  wire logic                            addr_word_access_i,
  output logic      [15:0]                     addr_o,
  // Stack pointer view
  output logic      [15:0]                     stack_pointer_o,
  // Program counter
  input  wire logic                            pc_load_i,
  input  wire logic [15:0]                     pc_data_i,
  input  wire logic                            vector_valid_i,
  input  wire logic [15:0]                     vector_data_i,
  output logic      [15:0]                     program_counter_o,
  output logic      [15:0]                     fetch_addr_o,
  output logic                                 vector_req_o,
  output logic      [15:0]                     vector_addr_o,
  // Flag register
  input  wire cpu_regs_pkg::flag_op_t          flag_op_i,
  input  wire logic [15:0]                     flag_wdata_i,
  input  wire logic                            exception_entry_i,
  input  wire cpu_regs_pkg::alu_kind_t         alu_kind_i,
  input  wire logic [16:0]                     alu_sum_i,
  input  wire logic                            alu_half_carry_i,
  input  wire logic                            alu_overflow_i,
  input  wire logic [7:0]                      alu_upd_mask_i,
  input  wire logic                            bit_acc_we_i,
  input  wire logic                            bit_acc_i,
  output logic      [7:0]                      condition_flags_o,
  output logic      [15:0]                     flags_push_word_o,
  output logic                                 irq_masked_o,
  output logic      [3:0]                      branch_cond_o,
  output logic                                 dec_adjust_half_o,
  output logic                                 bit_acc_o
);

  ////////////////////////////////////////////////////////////////////////
  // Word registers
  logic [WORD_W-1:0] word_q [NUM_WORDS];

  // Pairs of byte registers form each word
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WORDS; gi++)
    begin : g_reg
      word_reg u_word
      (
        .clk_sys_i (clk_sys_i),
        .wr_high_i (wr_sel_i == SEL_W'(gi) && (wr_size_i == WR_HIGH || wr_size_i == WR_WORD)),
        .wr_low_i  (wr_sel_i == SEL_W'(gi) && (wr_size_i == WR_LOW || wr_size_i == WR_WORD)),
        .wdata_i   (wr_size_i == WR_LOW ? {8'h00, wr_data_i[7:0]} :
                    wr_size_i == WR_HIGH ? {wr_data_i[7:0], 8'h00} : wr_data_i),
        .q_o       (word_q[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed
  {
    logic [15:0] pc;
    logic [15:0] fetch;
    logic [7:0]  flags;
    logic        boot;
    logic [15:0] rd_data;
    logic [15:0] addr;
    logic [15:0] sp;
  } state_t;

  state_t st;
  state_t next_st;

  logic [15:0] rd_word;
  logic [7:0]  res_byte;
  logic        res_msb;
  logic        res_zero;
  logic        res_carry;

  assign rd_word   = word_q[rd_sel_i];
  assign res_byte  = alu_sum_i[7:0];
  assign res_msb   = (alu_kind_i == ALU_WORD) ? alu_sum_i[15] : alu_sum_i[7];
  assign res_zero  = (alu_kind_i == ALU_WORD) ? (alu_sum_i[15:0] == 16'h0000) : (res_byte == 8'h00);
  assign res_carry = (alu_kind_i == ALU_WORD) ? alu_sum_i[16] : alu_sum_i[8];

  // Next-state logic; flag priority: exception, software op, ALU
  always_comb
  begin
    next_st = st;
    // Byte read places data in low lane
    if (rd_byte_i)
      next_st.rd_data = {8'h00, rd_high_i ? rd_word[15:8] : rd_word[7:0]};
    else
      next_st.rd_data = rd_word;
    // Word access forces even address
    next_st.addr = addr_word_access_i ? (word_q[addr_sel_i] & WORD_ALIGN_MASK)
                                      : word_q[addr_sel_i];
    next_st.sp   = word_q[STACK_INDEX];
    // Boot: wait for reset vector word
    if (st.boot)
    begin
      if (vector_valid_i)
      begin
        next_st.pc   = vector_data_i;
        next_st.boot = 1'b0;
      end
    end
    else if (pc_load_i)
      next_st.pc = pc_data_i;
    // Fetch address kept in a flop so the output needs no gate
    next_st.fetch = next_st.pc & WORD_ALIGN_MASK;
    // ALU-driven flags, only bits named in the update mask
    if (alu_kind_i != ALU_NONE)
    begin
      if (alu_upd_mask_i[FLAG_H])
        next_st.flags[FLAG_H] = alu_half_carry_i;
      if (alu_upd_mask_i[FLAG_N])
        next_st.flags[FLAG_N] = res_msb;
      if (alu_upd_mask_i[FLAG_Z])
        next_st.flags[FLAG_Z] = res_zero;
      if (alu_upd_mask_i[FLAG_V])
        next_st.flags[FLAG_V] = alu_overflow_i;
      if (alu_upd_mask_i[FLAG_C])
        next_st.flags[FLAG_C] = res_carry;
    end
    if (bit_acc_we_i)
      next_st.flags[FLAG_C] = bit_acc_i;
    // Software access; user bits only change here
    unique case (flag_op_i)
      FOP_LOAD: next_st.flags = flag_wdata_i[7:0];
      FOP_AND:  next_st.flags = st.flags & flag_wdata_i[7:0];
      FOP_OR:   next_st.flags = st.flags | flag_wdata_i[7:0];
      FOP_XOR:  next_st.flags = st.flags ^ flag_wdata_i[7:0];
      FOP_POP:  next_st.flags = flag_wdata_i[15:8];
      default:  ;
    endcase
    if (exception_entry_i)
      next_st.flags[FLAG_I] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register stage; only mask and boot reset, the rest stays undefined
  // One process owns the whole state word, so no field has two drivers
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st.boot          <= 1'b1;
      st.flags[FLAG_I] <= MASK_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rd_data_o         = st.rd_data;
  assign addr_o            = st.addr;
  assign stack_pointer_o   = st.sp;
  assign program_counter_o = st.pc;
  assign fetch_addr_o      = st.fetch;
  assign vector_req_o      = st.boot;
  assign vector_addr_o     = RESET_VECTOR_ADDR;
  assign condition_flags_o = st.flags;
  assign flags_push_word_o = {st.flags, st.flags};
  assign irq_masked_o      = st.flags[FLAG_I];
  assign branch_cond_o     = st.flags[3:0];
  assign dec_adjust_half_o = st.flags[FLAG_H];
  assign bit_acc_o         = st.flags[FLAG_C];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_mask_on_exc;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    exception_entry_i |=> irq_masked_o;
  endproperty
  a_mask_on_exc: assert property (p_mask_on_exc) else $error("mask not set on exception");

  property p_pc_vector;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (vector_req_o && vector_valid_i) |=> (program_counter_o == $past(vector_data_i)) && !vector_req_o;
  endproperty
  a_pc_vector: assert property (p_pc_vector) else $error("vector not loaded");

  property p_fetch_even;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    !vector_req_o |-> (fetch_addr_o[0] == 1'b0) && (fetch_addr_o[15:1] == program_counter_o[15:1]);
  endproperty
  a_fetch_even: assert property (p_fetch_even) else $error("fetch address odd");

  property p_push_copy;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (flag_op_i == FOP_LOAD && !exception_entry_i) |=> flags_push_word_o == {2{$past(flag_wdata_i[7:0])}};
  endproperty
  a_push_copy: assert property (p_push_copy) else $error("push copies differ");

  property p_pop_upper;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (flag_op_i == FOP_POP && !exception_entry_i) |=> condition_flags_o == $past(flag_wdata_i[15:8]);
  endproperty
  a_pop_upper: assert property (p_pop_upper) else $error("pop used wrong byte");

  property p_and_op;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (flag_op_i == FOP_AND && !exception_entry_i) |=>
      condition_flags_o == ($past(condition_flags_o) & $past(flag_wdata_i[7:0]));
  endproperty
  a_and_op: assert property (p_and_op) else $error("flag and wrong");

  property p_zero_flag;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (alu_kind_i == ALU_BYTE && alu_upd_mask_i[FLAG_Z] && flag_op_i == FOP_NONE) |=>
      condition_flags_o[FLAG_Z] == ($past(alu_sum_i[7:0]) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_carry_byte;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (alu_kind_i == ALU_BYTE && alu_upd_mask_i[FLAG_C] && !bit_acc_we_i && flag_op_i == FOP_NONE) |=>
      bit_acc_o == $past(alu_sum_i[8]);
  endproperty
  a_carry_byte: assert property (p_carry_byte) else $error("carry wrong");

  property p_word_write;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (wr_size_i == WR_WORD && wr_sel_i == STACK_INDEX) |=> ##1 stack_pointer_o == $past(wr_data_i, 2);
  endproperty
  a_word_write: assert property (p_word_write) else $error("stack write lost");

  property p_low_keeps_high;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (wr_size_i == WR_LOW && wr_sel_i == STACK_INDEX) |=>
      ##1 stack_pointer_o == {$past(word_q[STACK_INDEX][15:8], 2), $past(wr_data_i[7:0], 2)};
  endproperty
  a_low_keeps_high: assert property (p_low_keeps_high) else $error("byte write hit other half");

  // Boot and jump handling
  property p_boot_hold;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (vector_req_o && !vector_valid_i) |=> vector_req_o;
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot left without vector");

  property p_pc_load;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (pc_load_i && !vector_req_o) |=> program_counter_o == $past(pc_data_i);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("jump target lost");

  // Flag sources
  property p_bit_acc;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (bit_acc_we_i && flag_op_i == FOP_NONE) |=> bit_acc_o == $past(bit_acc_i);
  endproperty
  a_bit_acc: assert property (p_bit_acc) else $error("bit accumulator not written");

  property p_half_word;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (alu_kind_i == ALU_WORD && alu_upd_mask_i[FLAG_H] && flag_op_i == FOP_NONE) |=>
      dec_adjust_half_o == $past(alu_half_carry_i);
  endproperty
  a_half_word: assert property (p_half_word) else $error("word half carry wrong");

  property p_neg_word;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (alu_kind_i == ALU_WORD && alu_upd_mask_i[FLAG_N] && flag_op_i == FOP_NONE) |=>
      condition_flags_o[FLAG_N] == $past(alu_sum_i[15]);
  endproperty
  a_neg_word: assert property (p_neg_word) else $error("word sign flag wrong");

  // Read ports
  property p_byte_read_high;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (rd_byte_i && rd_high_i) |=> rd_data_o == {8'h00, $past(word_q[rd_sel_i][15:8])};
  endproperty
  a_byte_read_high: assert property (p_byte_read_high) else $error("high byte read wrong");

  property p_addr_word;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    addr_word_access_i |=> (addr_o[0] == 1'b0) && (addr_o[15:1] == $past(word_q[addr_sel_i][15:1]));
  endproperty
  a_addr_word: assert property (p_addr_word) else $error("word address not aligned");

  c_exc: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) exception_entry_i);
  c_boot: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) vector_req_o && vector_valid_i);
  c_pop: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) flag_op_i == FOP_POP);
  c_word: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) alu_kind_i == ALU_WORD);
  c_low: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) wr_size_i == WR_LOW && wr_sel_i == STACK_INDEX);

endmodule

//--- design/cpu_regs_pkg.sv
package cpu_regs_pkg;

  localparam int unsigned NUM_WORDS   = 8;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned SEL_W       = 3;
  localparam logic [2:0]  STACK_INDEX = 3'h7;

  // Flag bit positions
  localparam int unsigned FLAG_I  = 7;
  localparam int unsigned FLAG_U6 = 6;
  localparam int unsigned FLAG_H  = 5;
  localparam int unsigned FLAG_U4 = 4;
  localparam int unsigned FLAG_N  = 3;
  localparam int unsigned FLAG_Z  = 2;
  localparam int unsigned FLAG_V  = 1;
  localparam int unsigned FLAG_C  = 0;

  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
  localparam logic        MASK_RESET        = 1'b1;
  localparam logic [15:0] WORD_ALIGN_MASK   = 16'hfffe;

  // Register write sizes
  typedef enum logic [1:0]
  {
    WR_NONE,
    WR_HIGH,
    WR_LOW,
    WR_WORD
  } wr_size_t;

  // Operations on the flag register
  typedef enum logic [2:0]
  {
    FOP_NONE,
    FOP_LOAD,
    FOP_AND,
    FOP_OR,
    FOP_XOR,
    FOP_POP
  } flag_op_t;

  // Flag update source kinds
  typedef enum logic [1:0]
  {
    ALU_NONE,
    ALU_BYTE,
    ALU_WORD
  } alu_kind_t;

endpackage

//--- design/word_reg.sv
`timescale 1ns/1ns
// One word register with byte-lane writes
module word_reg
  import cpu_regs_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 wr_high_i,
  input  wire logic                 wr_low_i,
  input  wire logic [WORD_W-1:0]    wdata_i,
  output logic      [WORD_W-1:0]    q_o
);

  typedef struct packed
  {
    logic [BYTE_W-1:0] high;
    logic [BYTE_W-1:0] low;
  } word_state_t;

  word_state_t st;
  word_state_t next_st;

  // Untouched lane holds its value
  always_comb
  begin
    next_st = st;
    if (wr_high_i)
      next_st.high = wdata_i[15:8];
    if (wr_low_i)
      next_st.low = wdata_i[7:0];
  end

  // No reset: contents undefined after reset
  always_ff @(posedge clk_sys_i)
  begin
    st <= next_st;
  end

  assign q_o = st;

endmodule

//--- dv/cpu_register_set_and_flags_tb.sv
`timescale 1ns/1ns
module cpu_register_set_and_flags_tb;
  import cpu_regs_pkg::*;
  localparam logic [15:0] BOOT = 16'h1235;
  logic        clk_sys_i, rst_b_i, rd_byte_i, rd_high_i, addr_word_access_i, pc_load_i, vector_valid_i;
  logic        exception_entry_i, alu_half_carry_i, alu_overflow_i, bit_acc_we_i, bit_acc_i, m_word, m_sub;
  logic        vector_req_o, irq_masked_o, dec_adjust_half_o, bit_acc_o;
  wr_size_t    wr_size_i;
  flag_op_t    flag_op_i;
  alu_kind_t   alu_kind_i;
  logic [2:0]  wr_sel_i, rd_sel_i, addr_sel_i;
  logic [15:0] wr_data_i, rd_data_o, addr_o, stack_pointer_o, pc_data_i, vector_data_i, program_counter_o;
  logic [15:0] fetch_addr_o, vector_addr_o, flag_wdata_i, flags_push_word_o, m_a, m_b, v;
  logic [16:0] alu_sum_i;
  logic [7:0]  alu_upd_mask_i, condition_flags_o;
  logic [3:0]  branch_cond_o;
  int          bad_count, checks, n;

  cpu_register_set_and_flags dut_u (.clk_sys_i, .rst_b_i, .wr_size_i, .wr_sel_i, .wr_data_i, .rd_sel_i,
    .rd_byte_i, .rd_high_i, .rd_data_o, .addr_sel_i, .addr_word_access_i, .addr_o, .stack_pointer_o,
    .pc_load_i, .pc_data_i, .vector_valid_i, .vector_data_i, .program_counter_o, .fetch_addr_o,
    .vector_req_o, .vector_addr_o, .flag_op_i, .flag_wdata_i, .exception_entry_i, .alu_kind_i,
    .alu_sum_i, .alu_half_carry_i, .alu_overflow_i, .alu_upd_mask_i, .bit_acc_we_i, .bit_acc_i,
    .condition_flags_o, .flags_push_word_o, .irq_masked_o, .branch_cond_o, .dec_adjust_half_o, .bit_acc_o);
  datapath_model #(.BOOT_WORD(BOOT)) model_u (.clk_sys_i, .rst_b_i, .vector_req_i(vector_req_o),
    .word_i(m_word), .sub_i(m_sub), .a_i(m_a), .b_i(m_b), .sum_o(alu_sum_i), .half_o(alu_half_carry_i),
    .ovf_o(alu_overflow_i), .vector_valid_o(vector_valid_i), .vector_data_o(vector_data_i));

  ////////////////////////////////////////////////////////////
  // Compare and bus tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input wr_size_t sz, input logic [2:0] sel, input logic [15:0] d);
    @(posedge clk_sys_i);
    wr_size_i <= sz;
    wr_sel_i <= sel;
    wr_data_i <= d;
    @(posedge clk_sys_i);
    wr_size_i <= WR_NONE;
  endtask

  // Read data and address ports together; both land two edges after a write
  task automatic rd(input logic [2:0] sel, input logic [1:0] mode, input logic aw, input logic [15:0] ed,
                    input logic [15:0] ea);
    @(posedge clk_sys_i);
    rd_sel_i <= sel;
    addr_sel_i <= sel;
    {rd_byte_i, rd_high_i} <= mode;
    addr_word_access_i <= aw;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(rd_data_o, ed);
    chk(addr_o, ea);
  endtask

  task automatic flg(input flag_op_t op, input logic [15:0] d, input logic [7:0] e);
    @(posedge clk_sys_i);
    flag_op_i <= op;
    flag_wdata_i <= d;
    @(posedge clk_sys_i);
    flag_op_i <= FOP_NONE;
    @(negedge clk_sys_i);
    chk({8'h00, condition_flags_o}, {8'h00, e});
  endtask

  // Flags preset to d0 so untouched bits show whether the mask is honoured
  task automatic alu(input alu_kind_t k, input logic s, input logic [15:0] a, input logic [15:0] b,
                     input logic [7:0] mask, input logic [7:0] e);
    flg(FOP_LOAD, 16'h00d0, 8'hd0);
    @(posedge clk_sys_i);
    alu_kind_i <= k;
    m_word <= (k == ALU_WORD);
    m_sub <= s;
    m_a <= a;
    m_b <= b;
    alu_upd_mask_i <= mask;
    @(posedge clk_sys_i);
    alu_kind_i <= ALU_NONE;
    @(negedge clk_sys_i);
    chk({8'h00, condition_flags_o}, {8'h00, e});
    chk({12'h000, branch_cond_o}, {12'h000, e[3:0]});
    chk({15'h0000, dec_adjust_half_o}, {15'h0000, e[5]});
  endtask

  ////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Main sequence
  initial
  begin
    rst_b_i = 1'b0;
    {rd_byte_i, rd_high_i, addr_word_access_i, pc_load_i, exception_entry_i, bit_acc_we_i, bit_acc_i} = '0;
    {m_word, m_sub, wr_sel_i, rd_sel_i, addr_sel_i, wr_data_i, pc_data_i, flag_wdata_i, m_a, m_b} = '0;
    alu_upd_mask_i = 8'h00;
    wr_size_i = WR_NONE;
    flag_op_i = FOP_NONE;
    alu_kind_i = ALU_NONE;
    bad_count = 0;
    checks = 0;
    repeat (10) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk({15'h0000, irq_masked_o}, 16'h0001);
    chk({15'h0000, vector_req_o}, 16'h0001);
    chk(vector_addr_o, 16'h0000);
    // A jump request while the boot vector is pending must be ignored
    @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    pc_load_i <= 1'b1;
    pc_data_i <= 16'h4444;
    @(posedge clk_sys_i);
    pc_load_i <= 1'b0;
    for (n = 0; n < 20 && vector_req_o !== 1'b0; n++)
      @(negedge clk_sys_i);
    if (vector_req_o !== 1'b0)
    begin
      bad_count++;
      summarize();
    end
    chk(program_counter_o, BOOT);
    chk(fetch_addr_o, BOOT & 16'hfffe);
    @(posedge clk_sys_i);
    pc_load_i <= 1'b1;
    pc_data_i <= 16'habcd;
    @(posedge clk_sys_i);
    pc_load_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(program_counter_o, 16'habcd);
    chk(fetch_addr_o, 16'habcc);
    $display("test boot done");
    // Stack word first, then the rest; odd values expose address bit 0
    for (n = 7; n >= 0; n--)
      wr(WR_WORD, n[2:0], 16'(16'h1357 + n * 16'h2222));
    for (n = 0; n < 8; n++)
    begin
      v = 16'(16'h1357 + n * 16'h2222);
      rd(n[2:0], 2'b00, n[0], v, n[0] ? (v & 16'hfffe) : v);
    end
    chk(stack_pointer_o, 16'h0245);
    wr(WR_HIGH, 3'h2, 16'h00a5);
    rd(3'h2, 2'b00, 1'b1, 16'ha59b, 16'ha59a);
    wr(WR_LOW, 3'h2, 16'h005a);
    rd(3'h2, 2'b11, 1'b0, 16'h00a5, 16'ha55a);
    rd(3'h2, 2'b10, 1'b1, 16'h005a, 16'ha55a);
    rd(3'h3, 2'b00, 1'b0, 16'h79bd, 16'h79bd);
    wr(WR_LOW, 3'h7, 16'h00c3);
    repeat (2) @(negedge clk_sys_i);
    chk(stack_pointer_o, 16'h02c3);
    $display("test registers done");
    flg(FOP_LOAD, 16'h0000, 8'h00);
    chk({15'h0000, irq_masked_o}, 16'h0000);
    @(posedge clk_sys_i);
    exception_entry_i <= 1'b1;
    @(posedge clk_sys_i);
    exception_entry_i <= 1'b0;
    @(negedge clk_sys_i);
    chk({8'h00, condition_flags_o}, 16'h0080);
    chk({15'h0000, irq_masked_o}, 16'h0001);
    flg(FOP_LOAD, 16'h00ff, 8'hff);
    flg(FOP_AND, 16'h0055, 8'h55);
    flg(FOP_OR, 16'h0082, 8'hd7);
    flg(FOP_XOR, 16'h00ff, 8'h28);
    flg(FOP_POP, 16'h9a11, 8'h9a);
    chk(flags_push_word_o, 16'h9a9a);
    flg(FOP_LOAD, 16'h0050, 8'h50);
    @(posedge clk_sys_i);
    bit_acc_we_i <= 1'b1;
    bit_acc_i <= 1'b1;
    @(posedge clk_sys_i);
    bit_acc_we_i <= 1'b0;
    @(negedge clk_sys_i);
    chk({8'h00, condition_flags_o}, 16'h0051);
    chk({15'h0000, bit_acc_o}, 16'h0001);
    $display("test flag ops done");
    alu(ALU_BYTE, 1'b0, 16'h000f, 16'h0001, 8'h2f, 8'hf0);
    alu(ALU_BYTE, 1'b0, 16'h0080, 16'h0080, 8'h2f, 8'hd7);
    alu(ALU_BYTE, 1'b1, 16'h0000, 16'h0001, 8'h2f, 8'hf9);
    alu(ALU_BYTE, 1'b0, 16'h0080, 16'h0080, 8'h04, 8'hd4);
    alu(ALU_WORD, 1'b0, 16'h0800, 16'h0800, 8'h2f, 8'hf0);
    alu(ALU_WORD, 1'b0, 16'h7fff, 16'h0001, 8'h2f, 8'hfa);
    alu(ALU_WORD, 1'b1, 16'h1000, 16'h0001, 8'h2f, 8'hf0);
    $display("test alu flags done");
    summarize();
  end
endmodule

//--- dv/datapath_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// Far-side datapath: ALU result bits and boot vector read
module datapath_model
#(
  parameter logic [15:0] BOOT_WORD = 16'h1235,
  parameter int          VEC_WAIT  = 3
)
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        vector_req_i,
  input  wire logic        word_i,
  input  wire logic        sub_i,
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] b_i,
  output logic      [16:0] sum_o,
  output logic             half_o,
  output logic             ovf_o,
  output logic             vector_valid_o,
  output logic      [15:0] vector_data_o
);
  logic [15:0] am;
  logic [15:0] bm;
  logic [16:0] full;
  logic        sa;
  logic        sb;
  logic        sr;
  int          wait_cnt;

  // Carry-in of a bit is a^b^r, so one form serves add and subtract
  always_comb
  begin
    am     = word_i ? a_i : {8'h00, a_i[7:0]};
    bm     = word_i ? b_i : {8'h00, b_i[7:0]};
    full   = sub_i ? {1'b0, am} - {1'b0, bm} : {1'b0, am} + {1'b0, bm};
    sum_o  = word_i ? full : {8'h00, full[8:0]};
    half_o = word_i ? (am[12] ^ bm[12] ^ full[12]) : (am[4] ^ bm[4] ^ full[4]);
    sa     = word_i ? am[15] : am[7];
    sb     = word_i ? bm[15] : bm[7];
    sr     = word_i ? full[15] : full[7];
    ovf_o  = sub_i ? (sa != sb) && (sr != sa) : (sa == sb) && (sr != sa);
  end

  // One strobe after a memory wait; counter runs on so it never repeats
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wait_cnt       <= 0;
      vector_valid_o <= 1'b0;
    end
    else
    begin
      vector_valid_o <= vector_req_i && (wait_cnt == VEC_WAIT);
      if (vector_req_i)
        wait_cnt <= wait_cnt + 1;
    end
  end

  // Bus holds no stale word outside the strobe
  assign vector_data_o = vector_valid_o ? BOOT_WORD : ~BOOT_WORD;
endmodule
